// File: rtl/two_wire_slave_pkg.sv
// Constants, register map and state encoding of the two-wire slave
// transmitter. Assumes a 32-bit APB slave port on a 10 MHz pclk.

package two_wire_slave_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on APB
  localparam logic [7:0] OFS_OWN_ADDR = 8'h00; // Own slave address
  localparam logic [7:0] OFS_CONTROL  = 8'h04; // Serial control
  localparam logic [7:0] OFS_STATUS   = 8'h08; // Bus status, read only
  localparam logic [7:0] OFS_BUFFER   = 8'h0c; // Byte buffer

  ////////////////////////////////////////////////////////////////////////////
  // Control register bit positions
  localparam int CTL_FLAG  = 7; // Step done flag, write one clears
  localparam int CTL_ACK   = 6; // Acknowledge enable
  localparam int CTL_STA   = 5; // Start request
  localparam int CTL_STO   = 4; // Stop request
  localparam int CTL_WC    = 3; // Write collision, read only
  localparam int CTL_EN    = 2; // Interface enable
  localparam int CTL_IE    = 0; // Interrupt enable, stored only
  localparam int ADDR_GCE  = 0; // General call enable in own address

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] BUFFER_RST   = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Status codes (prescaler bits read as zero)
  localparam logic [7:0] ST_NONE      = 8'hf8; // Flag clear, no info
  localparam logic [7:0] ST_SR_OWN    = 8'h60; // Own address + write
  localparam logic [7:0] ST_SR_GCALL  = 8'h70; // General call
  localparam logic [7:0] ST_TX_ADDR   = 8'ha8; // Own address + read
  localparam logic [7:0] ST_TX_LOST   = 8'hb0; // Same, after lost arb
  localparam logic [7:0] ST_TX_ACK    = 8'hb8; // Byte sent, ACK back
  localparam logic [7:0] ST_TX_NACK   = 8'hc0; // Byte sent, NACK back
  localparam logic [7:0] ST_TX_LASTAK = 8'hc8; // Last byte, ACK back
  localparam logic [7:0] STATUS_MASK  = 8'hf8; // Prescaler bits zeroed
  localparam logic [6:0] GCALL_ADDR   = 7'h00; // General call address

  ////////////////////////////////////////////////////////////////////////////
  // Bit counts
  localparam logic [3:0] ADDR_BITS    = 4'h8; // Address plus direction
  localparam logic [3:0] TX_BITS_LEFT = 4'h7; // Bits after the first

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine, one-hot
  typedef enum logic [5:0] {
    LS_IDLE     = 6'b000001, // Unaddressed, watching for START
    LS_ADDR     = 6'b000010, // Shifting in address and direction
    LS_ADDR_ACK = 6'b000100, // Driving address acknowledge
    LS_TX       = 6'b001000, // Shifting out a data byte
    LS_TX_ACK   = 6'b010000, // Sampling master acknowledge
    LS_WAIT     = 6'b100000  // Flag set, clock stretched
  } link_state_t;

endpackage : two_wire_slave_pkg

// File: rtl/two_wire_slave_transmitter.sv
// Two-wire slave transmitter with APB register access.
// Assumes open-drain SCL/SDA resolved outside; pins arrive asynchronous
// and are synchronised to pclk. Sleep and arbitration inputs are pclk.
`timescale 1ns/1ps

module two_wire_slave_transmitter
(
  input  wire logic        pclk,            // System clock
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB direction
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        scl_i,           // Serial clock level
  output logic             scl_o,           // Serial clock drive value
  output logic             scl_oe,          // Pull serial clock low
  input  wire logic        sda_i,           // Serial data level
  output logic             sda_o,           // Serial data drive value
  output logic             sda_oe,          // Pull serial data low
  input  wire logic        arb_lost,        // Own master lost arbitration
  input  wire logic        deep_sleep,      // Non-idle sleep active
  output logic             wake_req,        // Address wake-up request
  output logic             start_queued     // START pending, bus free
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    logic                           rdy;     // APB ready
    logic [31:0]                    rdata;   // APB read data
    logic                           err;     // APB error
    logic [7:0]                     addr;    // Own slave address reg
    logic                           ack_en;  // Acknowledge enable
    logic                           sta;     // Start request
    logic                           sto;     // Stop request
    logic                           en;      // Interface enable
    logic                           ie;      // Interrupt enable
    logic                           wc;      // Write collision
    logic                           flag;    // Step done flag
    logic [7:0]                     status;  // Status code
    logic [7:0]                     buffer;  // Byte buffer
    logic                           scl_m;   // SCL sync stage one
    logic                           scl_s;   // SCL sync stage two
    logic                           scl_p;   // SCL previous
    logic                           sda_m;   // SDA sync stage one
    logic                           sda_s;   // SDA sync stage two
    logic                           sda_p;   // SDA previous
    two_wire_slave_pkg::link_state_t st;     // Link state
    logic [7:0]                     sh;      // Shift register
    logic [3:0]                     cnt;     // Bit counter
    logic                           rw;      // Direction bit
    logic                           gcall;   // Addressed by general call
    logic                           last;    // Current byte is last
    logic                           nack;    // Master answered NACK
    logic                           lost;    // Arbitration lost earlier
    logic                           busy;    // Bus between START, STOP
    logic                           scl_oe;  // SCL pull down
    logic                           sda_oe;  // SDA pull down
    logic                           wake;    // Wake request
    logic                           startq;  // START queued output
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Register select decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic       wr_done;   // APB write completes this edge
  logic       rd_access; // APB read access cycle, not yet ready
  logic       flag_clr;  // Software writes one to flag
  logic       scl_rise;  // Synchronised SCL rising edge
  logic       scl_fall;  // Synchronised SCL falling edge
  logic       start_det; // START seen on bus
  logic       stop_det;  // STOP seen on bus
  logic       match_own; // Address bits equal own address
  logic       match_gc;  // General call accepted
  logic [7:0] rd_mux;    // Read data selection
  logic [7:0] ctl_rd;    // Control register read view

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    wr_done   = psel && penable && s_q.rdy && pwrite;
    rd_access = psel && penable && !s_q.rdy && !pwrite;
    flag_clr  = wr_done && hit(paddr, two_wire_slave_pkg::OFS_CONTROL) &&
                pwdata[two_wire_slave_pkg::CTL_FLAG];
    scl_rise  = s_q.scl_s && !s_q.scl_p;
    scl_fall  = !s_q.scl_s && s_q.scl_p;
    start_det = s_q.scl_s && s_q.scl_p && !s_q.sda_s && s_q.sda_p;
    stop_det  = s_q.scl_s && s_q.scl_p && s_q.sda_s && !s_q.sda_p;
    match_own = (s_q.sh[7:1] == s_q.addr[7:1]);
    match_gc  = (s_q.sh[7:1] == two_wire_slave_pkg::GCALL_ADDR) &&
                s_q.addr[two_wire_slave_pkg::ADDR_GCE] && !s_q.sh[0];
    ctl_rd = 8'h00;
    ctl_rd[two_wire_slave_pkg::CTL_FLAG] = s_q.flag;
    ctl_rd[two_wire_slave_pkg::CTL_ACK]  = s_q.ack_en;
    ctl_rd[two_wire_slave_pkg::CTL_STA]  = s_q.sta;
    ctl_rd[two_wire_slave_pkg::CTL_STO]  = s_q.sto;
    ctl_rd[two_wire_slave_pkg::CTL_WC]   = s_q.wc;
    ctl_rd[two_wire_slave_pkg::CTL_EN]   = s_q.en;
    ctl_rd[two_wire_slave_pkg::CTL_IE]   = s_q.ie;

    // Two-flop synchronisers plus edge history
    s_d.scl_m = scl_i;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = sda_i;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;

    // APB: one wait state, answer registered
    rd_mux = 8'h00;
    unique case (1'b1)
      hit(paddr, two_wire_slave_pkg::OFS_OWN_ADDR): rd_mux = s_q.addr;
      hit(paddr, two_wire_slave_pkg::OFS_CONTROL):  rd_mux = ctl_rd;
      hit(paddr, two_wire_slave_pkg::OFS_STATUS):
        rd_mux = s_q.flag ? (s_q.status & two_wire_slave_pkg::STATUS_MASK)
                          : two_wire_slave_pkg::ST_NONE;
      hit(paddr, two_wire_slave_pkg::OFS_BUFFER):   rd_mux = s_q.buffer;
      default:                                      rd_mux = 8'h00;
    endcase
    s_d.rdy = psel && penable && !s_q.rdy;
    s_d.err = psel && penable && !s_q.rdy &&
              !(hit(paddr, two_wire_slave_pkg::OFS_OWN_ADDR) ||
                hit(paddr, two_wire_slave_pkg::OFS_CONTROL)  ||
                hit(paddr, two_wire_slave_pkg::OFS_STATUS)   ||
                hit(paddr, two_wire_slave_pkg::OFS_BUFFER));
    if (rd_access)
    begin
      s_d.rdata = {24'h000000, rd_mux};
    end

    // Register writes at the completing edge
    if (wr_done)
    begin
      if (hit(paddr, two_wire_slave_pkg::OFS_OWN_ADDR))
      begin
        s_d.addr = pwdata[7:0];
      end
      if (hit(paddr, two_wire_slave_pkg::OFS_CONTROL))
      begin
        s_d.ack_en = pwdata[two_wire_slave_pkg::CTL_ACK];
        s_d.sta    = pwdata[two_wire_slave_pkg::CTL_STA];
        s_d.sto    = pwdata[two_wire_slave_pkg::CTL_STO];
        s_d.en     = pwdata[two_wire_slave_pkg::CTL_EN];
        s_d.ie     = pwdata[two_wire_slave_pkg::CTL_IE];
      end
      if (hit(paddr, two_wire_slave_pkg::OFS_BUFFER))
      begin
        // Buffer writes only count while the flag is set
        if (s_q.flag)
        begin
          s_d.buffer = pwdata[7:0];
          s_d.wc     = 1'b0;
        end
        else
        begin
          s_d.wc = 1'b1;
        end
      end
    end
    // flag cleared only by writing one
    if (flag_clr)
    begin
      s_d.flag = 1'b0;
    end

    // Arbitration loss remembered until the next addressing
    if (arb_lost)
    begin
      s_d.lost = 1'b1;
    end

    // Bus busy tracking for the queued START
    if (start_det)
    begin
      s_d.busy = 1'b1;
    end
    else if (stop_det)
    begin
      s_d.busy = 1'b0;
    end
    // START queued output raised while bus is free
    s_d.startq = s_q.sta && s_q.en && !s_q.busy;

    // Wake request drops once the system runs again
    if (!deep_sleep)
    begin
      s_d.wake = 1'b0;
    end

    // Link state machine
    unique case (s_q.st)
      two_wire_slave_pkg::LS_IDLE:
      begin
        if (start_det)
        begin
          s_d.st  = two_wire_slave_pkg::LS_ADDR;
          s_d.cnt = 4'h0;
        end
      end
      two_wire_slave_pkg::LS_ADDR:
      begin
        if (scl_rise)
        begin
          s_d.sh  = {s_q.sh[6:0], s_q.sda_s};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        else if (scl_fall && s_q.cnt == two_wire_slave_pkg::ADDR_BITS)
        begin
          // same path answers in deep sleep
          if ((match_own || match_gc) && s_q.ack_en && s_q.en)
          begin
            s_d.st     = two_wire_slave_pkg::LS_ADDR_ACK;
            s_d.sda_oe = 1'b1;
            s_d.rw     = s_q.sh[0];
            s_d.gcall  = !match_own;
            s_d.wake   = deep_sleep;
          end
          else
          begin
            s_d.st = two_wire_slave_pkg::LS_IDLE;
          end
        end
      end
      two_wire_slave_pkg::LS_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          s_d.sda_oe = 1'b0;
          s_d.flag   = 1'b1;
          s_d.st     = two_wire_slave_pkg::LS_WAIT;
          s_d.lost   = 1'b0;
          if (s_q.rw)
          begin
            s_d.status = s_q.lost ? two_wire_slave_pkg::ST_TX_LOST
                                  : two_wire_slave_pkg::ST_TX_ADDR;
          end
          else
          begin
            s_d.status = s_q.gcall ? two_wire_slave_pkg::ST_SR_GCALL
                                   : two_wire_slave_pkg::ST_SR_OWN;
          end
        end
      end
      two_wire_slave_pkg::LS_TX:
      begin
        if (scl_fall)
        begin
          if (s_q.cnt == 4'h0)
          begin
            s_d.sda_oe = 1'b0;
            s_d.st     = two_wire_slave_pkg::LS_TX_ACK;
          end
          else
          begin
            s_d.sda_oe = !s_q.sh[7];
            s_d.sh     = {s_q.sh[6:0], 1'b1};
            s_d.cnt    = s_q.cnt - 4'h1;
          end
        end
      end
      two_wire_slave_pkg::LS_TX_ACK:
      begin
        if (scl_rise)
        begin
          s_d.nack = s_q.sda_s;
        end
        else if (scl_fall)
        begin
          s_d.flag = 1'b1;
          s_d.st   = two_wire_slave_pkg::LS_WAIT;
          if (s_q.nack)
          begin
            s_d.status = two_wire_slave_pkg::ST_TX_NACK;
          end
          else if (s_q.last)
          begin
            s_d.status = two_wire_slave_pkg::ST_TX_LASTAK;
          end
          else
          begin
            s_d.status = two_wire_slave_pkg::ST_TX_ACK;
          end
        end
      end
      two_wire_slave_pkg::LS_WAIT:
      begin
        if (flag_clr)
        begin
          if (s_q.status == two_wire_slave_pkg::ST_TX_ADDR ||
              s_q.status == two_wire_slave_pkg::ST_TX_LOST ||
              s_q.status == two_wire_slave_pkg::ST_TX_ACK)
          begin
            // load byte, ack bit marks last
            s_d.st     = two_wire_slave_pkg::LS_TX;
            s_d.sda_oe = !s_q.buffer[7];
            s_d.sh     = {s_q.buffer[6:0], 1'b1};
            s_d.cnt    = two_wire_slave_pkg::TX_BITS_LEFT;
            s_d.last   = !s_d.ack_en;
          end
          else
          begin
            s_d.st     = two_wire_slave_pkg::LS_IDLE;
            s_d.sda_oe = 1'b0;
          end
        end
      end
      default:
      begin
        s_d.st = two_wire_slave_pkg::LS_IDLE;
      end
    endcase

    // STOP or repeated START while addressed ends the transfer
    if (s_q.st != two_wire_slave_pkg::LS_WAIT &&
        s_q.st != two_wire_slave_pkg::LS_IDLE && (start_det || stop_det))
    begin
      s_d.st     = start_det ? two_wire_slave_pkg::LS_ADDR
                             : two_wire_slave_pkg::LS_IDLE;
      s_d.cnt    = 4'h0;
      s_d.sda_oe = 1'b0;
    end

    // clock held low from flag set in LS_WAIT until flag clear
    s_d.scl_oe = s_d.flag && (s_d.st == two_wire_slave_pkg::LS_WAIT);

    // Interface disabled: release bus and stop, from the writing edge on
    if (!s_d.en)
    begin
      s_d.st     = two_wire_slave_pkg::LS_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.scl_oe = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q        <= '0;
      s_q.addr   <= two_wire_slave_pkg::OWN_ADDR_RST;
      // buffer never loaded from the bus
      s_q.buffer <= two_wire_slave_pkg::BUFFER_RST;
      s_q.status <= two_wire_slave_pkg::ST_NONE;
      s_q.st     <= two_wire_slave_pkg::LS_IDLE;
      s_q.scl_m  <= 1'b1;
      s_q.scl_s  <= 1'b1;
      s_q.scl_p  <= 1'b1;
      s_q.sda_m  <= 1'b1;
      s_q.sda_s  <= 1'b1;
      s_q.sda_p  <= 1'b1;
      s_q.sh     <= 8'hff;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, drive values tied to zero
  assign prdata       = s_q.rdata;
  assign pready       = s_q.rdy;
  assign pslverr      = s_q.err;
  assign scl_o        = 1'b0;
  assign sda_o        = 1'b0;
  assign scl_oe       = s_q.scl_oe;
  assign sda_oe       = s_q.sda_oe;
  assign wake_req     = s_q.wake;
  assign start_queued = s_q.startq;

endmodule : two_wire_slave_transmitter

// File: testbench/two_wire_slave_checker_properties.sv
// Port checker for the two-wire slave transmitter, bound to its top.
// Assumes one pclk domain and the design package compiled first.
`timescale 1ns/1ps

module two_wire_slave_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        deep_sleep,
  input wire logic        wake_req
);
  // One domain: shared clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Completed APB write to the control register
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite &&
                  (paddr == two_wire_slave_pkg::OFS_CONTROL);

  // Access opens, waits one cycle, answers once
  sequence s_open;
    psel && $rose(penable);
  endsequence
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  // Flag clear while the clock is stretched
  sequence s_clear;
    ctl_wr && pwdata[two_wire_slave_pkg::CTL_FLAG] && scl_oe;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (s_open |-> s_answer)
    else $error("pready not one cycle after access start");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_flag_release: assert property (s_clear |=> !scl_oe)
    else $error("clock still held after flag clear");
  a_stretch_hold: assert property (scl_oe && !ctl_wr |=> scl_oe)
    else $error("clock stretch ended without flag clear");
  a_stretch_entry: assert property ($rose(scl_oe) |-> !scl_i && !sda_oe)
    else $error("stretch began with clock high or data held");
  a_sda_change: assert property
    ($changed(sda_oe) && !$past(ctl_wr) |-> !scl_i)
    else $error("data line changed while clock high");
  a_ctl_disable: assert property
    (ctl_wr && !pwdata[two_wire_slave_pkg::CTL_EN] |=> !scl_oe && !sda_oe)
    else $error("lines held after interface disable");
  a_wake_sleep: assert property (wake_req |-> $past(deep_sleep))
    else $error("wake request outside sleep");
endmodule : two_wire_slave_checker

bind two_wire_slave_transmitter two_wire_slave_checker u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .deep_sleep(deep_sleep), .wake_req(wake_req)
);

// File: testbench/i2c_master_model.sv
// Behavioural master receiver on the two-wire bus, 800 ns bit period.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/1ps

module i2c_master_model
(
  input  wire logic pclk,  // Bench system clock
  input  wire logic scl,   // Resolved clock wire
  input  wire logic sda,   // Resolved data wire
  output logic      scl_m, // Master clock, low pulls
  output logic      sda_m  // Master data, low pulls
);
  // Lines released; clock stands still between frames
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Release clock and wait out a stretch by the slave
  task automatic rise();
    int k;
    scl_m <= 1'b1;
    tick(1);
    for (k = 0; k < 5000 && scl !== 1'b1; k++)
      tick(1);
  endtask : rise

  // One bit: low five cycles, high three, sample before the fall
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    tick(4);
    rise();
    tick(2);
    r = sda;
    scl_m <= 1'b0;
    tick(1);
  endtask : bit_x

  // START or repeated START, ends with clock low
  task automatic start_c();
    sda_m <= 1'b1;
    tick(4);
    rise();
    tick(3);
    sda_m <= 1'b0;
    tick(3);
    scl_m <= 1'b0;
    tick(1);
  endtask : start_c

  // STOP, leaves the bus idle
  task automatic stop_c();
    sda_m <= 1'b0;
    tick(4);
    rise();
    tick(3);
    sda_m <= 1'b1;
    tick(4);
  endtask : stop_c

  // Eight bits MSB first; ones let the slave drive
  task automatic byte8(input logic [7:0] d, output logic [7:0] q);
    int i;
    for (i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
  endtask : byte8
endmodule : i2c_master_model

// File: testbench/two_wire_slave_transmitter_tb_top.sv
// Self-checking bench: APB software plus a bus master model.
// Assumes package, master model and bound checker compile first.
`timescale 1ns/1ps

module two_wire_slave_transmitter_tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, scl_oe, sda_oe, ak, err_s;
  logic        arb_lost, deep_sleep, wake_req, start_queued;
  logic        scl_m, sda_m, scl_o, sda_o;
  logic [7:0]  paddr, q8;
  logic [31:0] pwdata, prdata, rq;
  int          bad_count, num_checks;
  // Open-drain wires with pull-ups
  wire         scl = scl_m & ~scl_oe;
  wire         sda = sda_m & ~sda_oe;
  // Own address, control, address and direction, expected status
  logic [31:0] cs [6] = '{32'h55442bf8, 32'h55440070, 32'h544400f8,
                          32'h550455f8, 32'h554055f8, 32'h55445460};

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  two_wire_slave_transmitter u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .arb_lost(arb_lost), .deep_sleep(deep_sleep), .wake_req(wake_req),
    .start_queued(start_queued)
  );
  i2c_master_model u_m
  (
    .pclk(pclk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // APB transfer: hold until pready, take data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++k < 20);
    rq = prdata;
    err_s = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rq);
  endtask : rdc

  task automatic wctl(input logic [7:0] d);
    apb(1'b1, two_wire_slave_pkg::OFS_CONTROL, 32'(d));
  endtask : wctl

  task automatic rst(input logic [7:0] e);
    repeat (4) @(posedge pclk);
    rdc("status", two_wire_slave_pkg::OFS_STATUS, 32'(e));
  endtask : rst

  // Address frame; ack seen as wire level, then status
  task automatic adr(input logic [7:0] ar, input logic [7:0] es);
    u_m.start_c();
    u_m.byte8(ar, q8);
    u_m.bit_x(1'b1, ak);
    chk("address ack", 32'(es == two_wire_slave_pkg::ST_NONE), 32'(ak));
    rst(es);
  endtask : adr

  // Master reads one byte and answers with mack (0 is ACK)
  task automatic rx(input logic mack, input logic [7:0] eb, es);
    u_m.byte8(8'hff, q8);
    u_m.bit_x(mack, ak);
    chk("read byte", 32'(eb), 32'(q8));
    rst(es);
  endtask : rx

  task automatic end_of_test();
    $display("TB: checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, arb_lost, deep_sleep} = 6'h0;
    {paddr, pwdata, bad_count, num_checks} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("own address", 8'h00, 32'(two_wire_slave_pkg::OWN_ADDR_RST));
    rdc("control", two_wire_slave_pkg::OFS_CONTROL, 32'h0);
    rdc("buffer", 8'h0c, 32'(two_wire_slave_pkg::BUFFER_RST));
    rst(two_wire_slave_pkg::ST_NONE);
    rdc("unmapped", 8'h10, 32'h0);
    chk("slave error", 32'h1, 32'(err_s));
    chk("drive values", 32'h0, 32'({scl_o, sda_o}));
    $display("TB: reset test done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'h00, 32'(cs[i][31:24]));
      wctl(cs[i][23:16]);
      adr(cs[i][15:8], cs[i][7:0]);
      wctl(8'hc4);
      u_m.stop_c();
    end
    $display("TB: address test done");
    adr(8'h55, two_wire_slave_pkg::ST_TX_ADDR);
    chk("scl stretch", 32'h1, 32'(scl_oe));
    apb(1'b1, 8'h0c, 32'ha5);
    wctl(8'hc4);
    rx(1'b0, 8'ha5, two_wire_slave_pkg::ST_TX_ACK);
    apb(1'b1, 8'h0c, 32'h3c);
    wctl(8'h84);
    rx(1'b0, 8'h3c, two_wire_slave_pkg::ST_TX_LASTAK);
    wctl(8'hc4);
    rx(1'b0, 8'hff, two_wire_slave_pkg::ST_NONE);
    u_m.stop_c();
    $display("TB: transmit test done");
    arb_lost <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    adr(8'h55, two_wire_slave_pkg::ST_TX_LOST);
    apb(1'b1, 8'h0c, 32'h96);
    wctl(8'hc4);
    rx(1'b1, 8'h96, two_wire_slave_pkg::ST_TX_NACK);
    wctl(8'hc4);
    u_m.stop_c();
    deep_sleep <= 1'b1;
    adr(8'h55, two_wire_slave_pkg::ST_TX_ADDR);
    chk("wake request", 32'h1, 32'(wake_req));
    chk("scl held", 32'h1, 32'(scl_oe));
    deep_sleep <= 1'b0;
    wctl(8'h84);
    chk("wake dropped", 32'h0, 32'(wake_req));
    rx(1'b1, 8'h96, two_wire_slave_pkg::ST_TX_NACK);
    wctl(8'hc4);
    u_m.stop_c();
    wctl(8'h64);
    @(posedge pclk);
    chk("start queued", 32'h1, 32'(start_queued));
    adr(8'h55, two_wire_slave_pkg::ST_TX_ADDR);
    wctl(8'h40);
    chk("scl released", 32'h0, 32'(scl_oe));
    u_m.stop_c();
    $display("TB: sleep and start test done");
    end_of_test();
  end

  // Watchdog for a hung bus or bus access
  initial
  begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
endmodule : two_wire_slave_transmitter_tb_top
